// ===== design/deo_pkg.sv
// Shared constants for the debug event and ownership block.
// Assumes LSB-first bit numbering: bit 31 is the leftmost field bit.
package deo_pkg;

  // Software special-register numbers
  localparam logic [9:0] SPR_EVSEL = 10'h03cf;
  localparam logic [9:0] SPR_ACQ   = 10'h0240;
  localparam logic [9:0] SPR_OWN   = 10'h0390;
  localparam logic [9:0] SPR_CTL0  = 10'h0391;
  localparam logic [9:0] SPR_CNT   = 10'h0392;
  localparam logic [9:0] SPR_STAT  = 10'h0393;

  // Register index, shared by software and debugger decode
  localparam logic [3:0] RA_XCTL  = 4'h0;
  localparam logic [3:0] RA_EMUC  = 4'h1;
  localparam logic [3:0] RA_OWN   = 4'h2;
  localparam logic [3:0] RA_CTL0  = 4'h3;
  localparam logic [3:0] RA_CNT   = 4'h4;
  localparam logic [3:0] RA_STAT  = 4'h5;
  localparam logic [3:0] RA_XSTAT = 4'h6;
  localparam logic [3:0] RA_EVSEL = 4'h7;
  localparam logic [3:0] RA_ACQ   = 4'h8;
  localparam logic [3:0] RA_NONE  = 4'hf;

  // Field positions
  localparam int B_XM   = 31;
  localparam int B_IOWN = 31;
  localparam int B_DQM  = 3;
  localparam int RST_LO = 28;
  localparam int TAG_LO = 24;
  localparam int WP0    = 12;
  localparam int WP1    = 13;
  localparam int WP2    = 20;
  localparam int WP3    = 21;

  // Masks and reset values
  localparam logic [31:0] XM_M    = 32'h8000_0000;
  localparam logic [31:0] RST_M   = 32'h3000_0000;
  localparam logic [31:0] XCTL_M  = 32'hf000_0000;
  localparam logic [31:0] RST_VAL = 32'h0000_0000;

endpackage

// ===== design/deo_core.sv
// Debug resource ownership, event pulse and acquisition message logic.
// Assumes core-side inputs are on core_clk_in, debugger port on tck_in.
`timescale 1ns/1ps
`default_nettype none

////////////////////////////////////////////////////////////////////////
module deo_core
  import deo_pkg::*;
(
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        ce_in,
  input  wire logic        proc_rst_in,
  input  wire logic [1:0]  reset_type_in,
  input  wire logic        spr_wr_in,
  input  wire logic        spr_rd_in,
  input  wire logic [9:0]  spr_num_in,
  input  wire logic [31:0] spr_wdata_in,
  input  wire logic [31:0] evt_in,
  input  wire logic        emulation_port_enable_in,
  input  wire logic        debug_entry_request_n_in,
  input  wire logic        tck_in,
  input  wire logic        tck_rst_in,
  input  wire logic        dbg_req_in,
  input  wire logic        dbg_wr_in,
  input  wire logic [3:0]  dbg_addr_in,
  input  wire logic [31:0] dbg_wdata_in,
  output logic [31:0]      spr_rdata_out,
  output logic             spr_rvalid_out,
  output logic [7:0]       evt_pulse_out,
  output logic [31:0]      watchpoint_out,
  output logic [7:0]       acq_tag_out,
  output logic [31:0]      acq_data_out,
  output logic             acq_stb_out,
  output logic             halt_req_out,
  output logic             dbg_irq_out,
  output logic             dbg_ack_out,
  output logic             dbg_busy_out,
  output logic [31:0]      dbg_rdata_out
);

  ////////////////////////////////////////////////////////////////////
  typedef struct packed {
    logic [31:0] own_r;
    logic [31:0] ctl0_r;
    logic [31:0] cnt_r;
    logic [31:0] stat_r;
    logic [31:0] xstat_r;
    logic [7:0]  tag_r;
    logic [7:0]  pulse_r;
    logic [31:0] acq_r;
    logic [31:0] wp_r;
    logic        acq_stb_r;
    logic        halt_r;
    logic        irq_r;
    logic [31:0] rdata_r;
    logic        rvalid_r;
    logic [1:0]  xm_s;
    logic [1:0]  emen_s;
    logic [1:0]  der_s;
    logic [1:0]  rqc_s;
    logic [2:0]  req_s;
    logic        ack_t_r;
    logic [31:0] hold_r;
  } deo_core_t;

  typedef struct packed {
    logic [31:0] xctl_r;
    logic        emuc_r;
    logic        busy_r;
    logic        req_t_r;
    logic        wr_r;
    logic [3:0]  addr_r;
    logic [31:0] wd_r;
    logic [2:0]  ack_s;
    logic        ack_r;
    logic [31:0] rd_r;
  } deo_link_t;

  deo_core_t   c;
  deo_core_t   n;
  deo_link_t   l;
  deo_link_t   m;
  logic        xm_raw;
  logic        en;
  logic        xm_on;
  logic        acq_ok;
  logic        dbg_go;
  logic        ev_wr;
  logic        acq_wr;
  logic        ctl_wr;
  logic [3:0]  sidx;
  logic [31:0] smask;
  logic [31:0] sw_own;
  logic [31:0] ctl0_hw;

  ////////////////////////////////////////////////////////////////////
  // Software-owned control bits; internal ownership gates all but one
  function automatic logic [31:0] soft_mask(input logic [31:0] own);
    soft_mask = own[B_IOWN] ? (own & ~XM_M) : RST_VAL;
  endfunction

  function automatic logic [3:0] spr_idx(input logic [9:0] num);
    spr_idx = RA_NONE;
    case (num)
      SPR_EVSEL: spr_idx = RA_EVSEL;
      SPR_ACQ:   spr_idx = RA_ACQ;
      SPR_OWN:   spr_idx = RA_OWN;
      SPR_CTL0:  spr_idx = RA_CTL0;
      SPR_CNT:   spr_idx = RA_CNT;
      SPR_STAT:  spr_idx = RA_STAT;
      default:   spr_idx = RA_NONE;
    endcase
  endfunction

  function automatic logic [31:0] read_reg(input deo_core_t s,
                                           input logic [3:0] idx,
                                           input logic       xm);
    read_reg = RST_VAL;
    case (idx)
      RA_OWN:   read_reg = s.own_r;
      RA_CTL0:  read_reg = s.ctl0_r | (xm ? XM_M : RST_VAL);
      RA_CNT:   read_reg = s.cnt_r;
      RA_STAT:  read_reg = s.stat_r;
      RA_XSTAT: read_reg = s.xstat_r;
      // Pulse field reads back zero
      RA_EVSEL: read_reg = {s.tag_r, 24'h00_0000};
      RA_ACQ:   read_reg = s.acq_r;
      default:  read_reg = RST_VAL;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////
  assign xm_raw  = c.xm_s[1];
  assign en      = c.emen_s[1];
  assign xm_on   = xm_raw & en;
  assign smask   = soft_mask(c.own_r);
  assign sw_own  = xm_on ? smask : ~RST_VAL;
  assign acq_ok  = !xm_on | c.own_r[B_DQM];
  assign dbg_go  = c.req_s[2] ^ c.req_s[1];
  assign sidx    = spr_idx(spr_num_in);
  assign ev_wr   = spr_wr_in & (sidx == RA_EVSEL);
  assign acq_wr  = spr_wr_in & (sidx == RA_ACQ);
  assign ctl_wr  = spr_wr_in & (sidx == RA_CTL0);
  assign ctl0_hw = c.ctl0_r & ~smask;

  ////////////////////////////////////////////////////////////////////
  // Core clock domain
  always_comb begin
    logic [31:0] clr_s;
    logic [31:0] clr_x;
    logic [31:0] set_s;
    logic [31:0] set_x;
    logic [31:0] wm;
    logic [31:0] rm;
    clr_s = RST_VAL;
    clr_x = RST_VAL;
    set_s = RST_VAL;
    set_x = RST_VAL;
    wm    = RST_VAL;
    rm    = RST_VAL;
    n     = c;
    if (ce_in) begin
      n.xm_s   = {c.xm_s[0], l.xctl_r[B_XM]};
      n.emen_s = {c.emen_s[0], emulation_port_enable_in};
      n.der_s  = {c.der_s[0], debug_entry_request_n_in};
      n.rqc_s  = {c.rqc_s[0], l.emuc_r};
      n.req_s  = {c.req_s[1:0], l.req_t_r};
      // One-cycle strobes drop unless rewritten
      n.pulse_r   = 8'h00;
      n.wp_r      = RST_VAL;
      n.acq_stb_r = 1'b0;
      n.rvalid_r  = spr_rd_in;
      n.rdata_r   = RST_VAL;
      if (spr_rd_in) begin
        n.rdata_r = read_reg(c, sidx, xm_raw);
        if ((sidx == RA_EVSEL || sidx == RA_ACQ) && !acq_ok) begin
          n.rdata_r = RST_VAL;
        end
      end
      // Mode bit itself is never writable by software
      wm = xm_on ? smask : ~XM_M;
      if (spr_wr_in) begin
        case (sidx)
          RA_CTL0: begin
            n.ctl0_r = (c.ctl0_r & ~wm) | (spr_wdata_in & wm);
          end
          RA_CNT: begin
            n.cnt_r = spr_wdata_in;
          end
          RA_STAT: begin
            clr_s = spr_wdata_in & sw_own;
          end
          RA_EVSEL: begin
            n.pulse_r = spr_wdata_in[7:0];
            if (en) begin
              n.wp_r[WP0] = spr_wdata_in[0];
              n.wp_r[WP1] = spr_wdata_in[1];
              n.wp_r[WP2] = spr_wdata_in[2];
              n.wp_r[WP3] = spr_wdata_in[3];
            end
            if (acq_ok) begin
              n.tag_r = spr_wdata_in[TAG_LO +: 8];
            end
          end
          RA_ACQ: begin
            if (acq_ok) begin
              n.acq_r     = spr_wdata_in;
              n.acq_stb_r = 1'b1;
            end
          end
          default: begin
          end
        endcase
      end
      // Debugger access lands after software; debugger wins a clash
      if (dbg_go) begin
        if (l.wr_r) begin
          case (l.addr_r)
            RA_OWN:   n.own_r = l.wd_r;
            RA_CTL0:  n.ctl0_r = l.wd_r & ~XM_M;
            RA_CNT:   n.cnt_r = l.wd_r;
            RA_STAT:  clr_s = clr_s | l.wd_r;
            RA_XSTAT: clr_x = l.wd_r;
            RA_EVSEL: n.tag_r = l.wd_r[TAG_LO +: 8];
            RA_ACQ:   n.acq_r = l.wd_r;
            default: begin
            end
          endcase
        end
        n.hold_r  = read_reg(c, l.addr_r, xm_raw);
        n.ack_t_r = ~c.ack_t_r;
      end
      // Status: a set in the clearing cycle wins
      set_s    = en ? (evt_in & sw_own) : RST_VAL;
      set_x    = en ? (evt_in & ~sw_own) : RST_VAL;
      n.stat_r = (c.stat_r & ~clr_s) | set_s;
      n.xstat_r = xm_on ? ((c.xstat_r & ~clr_x) | set_x) : RST_VAL;
      n.irq_r  = |set_s;
      n.halt_r = en & ((|set_x) | (xm_on & !c.der_s[1]) | c.rqc_s[1]);
      if (proc_rst_in) begin
        rm       = xm_on ? smask : ~RST_VAL;
        n.ctl0_r = n.ctl0_r & ~rm & ~RST_M;
        n.cnt_r  = n.cnt_r & ~rm;
        n.stat_r[RST_LO +: 2] = reset_type_in;
        if (acq_ok) begin
          n.tag_r = 8'h00;
          n.acq_r = RST_VAL;
        end
        n.pulse_r   = 8'h00;
        n.wp_r      = RST_VAL;
        n.acq_stb_r = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      c <= '0;
    end else begin
      c <= n;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Link clock domain: local registers answer without the core clock
  always_comb begin
    m       = l;
    m.ack_s = {l.ack_s[1:0], c.ack_t_r};
    m.ack_r = 1'b0;
    if (l.busy_r) begin
      if (l.ack_s[2] ^ l.ack_s[1]) begin
        m.rd_r   = c.hold_r;
        m.ack_r  = 1'b1;
        m.busy_r = 1'b0;
      end
    end else if (dbg_req_in) begin
      if (dbg_addr_in == RA_XCTL) begin
        // Only the mode bits change; control zero is untouched
        if (dbg_wr_in) begin
          m.xctl_r = dbg_wdata_in & XCTL_M;
        end
        m.rd_r  = l.xctl_r;
        m.ack_r = 1'b1;
      end else if (dbg_addr_in == RA_EMUC) begin
        if (dbg_wr_in) begin
          m.emuc_r = dbg_wdata_in[0];
        end
        m.rd_r  = {31'h0000_0000, l.emuc_r};
        m.ack_r = 1'b1;
      end else begin
        m.wr_r    = dbg_wr_in;
        m.addr_r  = dbg_addr_in;
        m.wd_r    = dbg_wdata_in;
        m.req_t_r = ~l.req_t_r;
        m.busy_r  = 1'b1;
      end
    end
  end

  always_ff @(posedge tck_in) begin
    if (tck_rst_in) begin
      l <= '0;
    end else begin
      l <= m;
    end
  end

  ////////////////////////////////////////////////////////////////////
  assign spr_rdata_out  = c.rdata_r;
  assign spr_rvalid_out = c.rvalid_r;
  assign evt_pulse_out  = c.pulse_r;
  assign watchpoint_out = c.wp_r;
  assign acq_tag_out    = c.tag_r;
  assign acq_data_out   = c.acq_r;
  assign acq_stb_out    = c.acq_stb_r;
  assign halt_req_out   = c.halt_r;
  assign dbg_irq_out    = c.irq_r;
  assign dbg_ack_out    = l.ack_r;
  assign dbg_busy_out   = l.busy_r;
  assign dbg_rdata_out  = l.rd_r;

  ////////////////////////////////////////////////////////////////////
  pulse_wr_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ce_in && ev_wr && !proc_rst_in |=> evt_pulse_out == $past(spr_wdata_in[7:0]))
    else $error("event pulse does not follow write");
  pulse_one_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ce_in && (|evt_pulse_out) && !ev_wr |=> evt_pulse_out == 8'h00)
    else $error("event pulse longer than one clock");
  wp_map_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    watchpoint_out[WP2] |-> evt_pulse_out[2] && watchpoint_out[WP0] == evt_pulse_out[0])
    else $error("watchpoint not tied to event pulse");
  acq_send_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ce_in && acq_wr && acq_ok && !proc_rst_in && !dbg_go
    |=> acq_stb_out && acq_data_out == $past(spr_wdata_in))
    else $error("acquisition message not sent");
  acq_block_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ce_in && acq_wr && !acq_ok && !dbg_go |=> !acq_stb_out && $stable(acq_data_out))
    else $error("blocked acquisition write took effect");
  rst_type_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ce_in && proc_rst_in
    |=> c.stat_r[RST_LO +: 2] == $past(reset_type_in) && (c.ctl0_r & RST_M) == RST_VAL)
    else $error("reset type not recorded");
  rst_keep_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ce_in && proc_rst_in && !acq_ok && !dbg_go |=> $stable(acq_tag_out))
    else $error("hardware-owned tag cleared by reset");
  ctl_lock_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ce_in && ctl_wr && xm_on && !dbg_go && !proc_rst_in |=> $stable(ctl0_hw))
    else $error("software changed hardware-owned control");
  halt_hw_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ce_in && en && (|(evt_in & ~sw_own))
    |=> halt_req_out && (c.xstat_r & $past(evt_in & ~sw_own)) == $past(evt_in & ~sw_own))
    else $error("hardware-owned event did not halt");
  block_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    ce_in && !en |=> !halt_req_out && !dbg_irq_out && watchpoint_out == RST_VAL)
    else $error("emulation disable did not block");
  freeze_a: assert property (@(posedge core_clk_in) disable iff (rst_in)
    !ce_in |=> $stable(c))
    else $error("state moved with clock enable low");
  xctl_wr_a: assert property (@(posedge tck_in) disable iff (tck_rst_in)
    !l.busy_r && dbg_req_in && dbg_wr_in && dbg_addr_in == RA_XCTL
    |=> l.xctl_r == ($past(dbg_wdata_in) & XCTL_M) && dbg_ack_out)
    else $error("debugger control write lost");
  pulse_c: cover property (@(posedge core_clk_in) disable iff (rst_in) |evt_pulse_out);
  acq_c:   cover property (@(posedge core_clk_in) disable iff (rst_in) acq_stb_out);
  halt_c:  cover property (@(posedge core_clk_in) disable iff (rst_in) halt_req_out);
  ack_c:   cover property (@(posedge tck_in) disable iff (tck_rst_in)
    dbg_ack_out && !l.busy_r);

endmodule

`default_nettype wire

// ===== verification/deo_dbg_model.sv
// Debugger stand-in: link clock, link reset, one access at a time.
// Waits up to 16 link clocks for the acknowledge; link clock runs only during link reset and within an access.
`timescale 1ns/1ps
`default_nettype none
module deo_dbg_model (
  output logic             tck_out,
  output logic             tck_rst_out,
  output logic             req_out,
  output logic             wr_out,
  output logic [3:0]       addr_out,
  output logic [31:0]      wdata_out,
  input  wire logic        ack_in,
  input  wire logic [31:0] rdata_in
);
  bit run = 1'b1;
  initial begin
    tck_out = 1'b0;
    tck_rst_out = 1'b1;
    req_out = 1'b0;
    wr_out = 1'b0;
    addr_out = 4'h0;
    wdata_out = 32'h0000_0000;
  end
  // Stops only when low, so no runt pulse
  always #32 if (run || tck_out) tck_out = ~tck_out;
  task automatic reset_link();
    repeat (3) @(posedge tck_out);
    @(negedge tck_out);
    tck_rst_out = 1'b0;
    run = 1'b0;
  endtask
  task automatic xfer(input logic w, input logic [3:0] a, input logic [31:0] d,
                      output logic [31:0] q);
    run = 1'b1;
    @(negedge tck_out);
    req_out = 1'b1;
    wr_out = w;
    addr_out = a;
    wdata_out = d;
    @(negedge tck_out);
    // Pulse only: a held request is taken again after the answer
    req_out = 1'b0;
    for (int n = 0; n < 16 && ack_in !== 1'b1; n++) @(negedge tck_out);
    q = (ack_in === 1'b1) ? rdata_in : 32'hxxxx_xxxx;
    // Released lines show the inverse, never a stale copy
    wr_out = ~w;
    addr_out = ~a;
    wdata_out = ~d;
    run = 1'b0;
  endtask
endmodule
`default_nettype wire

// ===== verification/debug_event_ownership_and_signals_test.sv
// Bench for the debug event and ownership block.
// Assumes the debugger model drives the link side.
`timescale 1ns/1ps
`default_nettype none
module debug_event_ownership_and_signals_test
  import deo_pkg::*;
;
  logic        clk = 1'b0;
  logic        rst = 1'b1;
  logic        ce = 1'b1;
  logic        prst = 1'b0;
  logic [1:0]  rtype = 2'b10;
  logic        swr = 1'b0;
  logic        srd = 1'b0;
  logic [9:0]  snum = 10'h000;
  logic [31:0] swd = 32'h0000_0000;
  logic [31:0] evt = 32'h0000_0000;
  logic        epe = 1'b1;
  logic        den_n = 1'b1;
  wire         tck, trst, dreq, dwr, ack, rvalid, stb, halt, irq, busy;
  wire [3:0]   daddr;
  wire [7:0]   pulse, tag;
  wire [31:0]  dwd, drd, rdata, wp, adata;
  int          n_fail = 0;
  int          compares = 0;
  logic [31:0] lf = 32'h5644;
  logic [31:0] q;
  logic [31:0] v;
  logic [1:0]  hs;
  always #2.5 clk = ~clk;
  deo_core u_deo_core (
    .core_clk_in(clk), .rst_in(rst), .ce_in(ce), .proc_rst_in(prst),
    .reset_type_in(rtype), .spr_wr_in(swr), .spr_rd_in(srd), .spr_num_in(snum),
    .spr_wdata_in(swd), .evt_in(evt), .emulation_port_enable_in(epe),
    .debug_entry_request_n_in(den_n), .tck_in(tck), .tck_rst_in(trst),
    .dbg_req_in(dreq), .dbg_wr_in(dwr), .dbg_addr_in(daddr), .dbg_wdata_in(dwd),
    .spr_rdata_out(rdata), .spr_rvalid_out(rvalid), .evt_pulse_out(pulse),
    .watchpoint_out(wp), .acq_tag_out(tag), .acq_data_out(adata), .acq_stb_out(stb),
    .halt_req_out(halt), .dbg_irq_out(irq), .dbg_ack_out(ack), .dbg_busy_out(busy),
    .dbg_rdata_out(drd));
  deo_dbg_model u_deo_dbg_model (
    .tck_out(tck), .tck_rst_out(trst), .req_out(dreq), .wr_out(dwr),
    .addr_out(daddr), .wdata_out(dwd), .ack_in(ack), .rdata_in(drd));
  ////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  function automatic logic [31:0] wpx(input logic [7:0] p);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[12] = p[0];
    w[13] = p[1];
    w[20] = p[2];
    w[21] = p[3];
    return w;
  endfunction
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_fail++;
      $display("unexpected at %0t: seen %h want %h", $time, s, e);
    end
  endtask
  task automatic sw(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(negedge clk);
    swr = w;
    srd = !w;
    snum = a;
    swd = d;
    @(negedge clk);
    swr = 1'b0;
    srd = 1'b0;
    q = (rvalid === 1'b1) ? rdata : 32'hxxxx_xxxx;
  endtask
  task automatic dbg(input logic w, input logic [3:0] a, input logic [31:0] d);
    fork
      u_deo_dbg_model.xfer(w, a, d, q);
      begin
        // Busy only for registers that live behind the core clock
        @(posedge dreq);
        @(negedge tck);
        chk(32'(busy), 32'(a > RA_EMUC));
      end
    join
  endtask
  task automatic wait_h(input logic e);
    for (int k = 0; k < 40 && halt !== e; k++) @(negedge clk);
    chk(32'(halt), 32'(e));
  endtask
  task automatic fire(input logic [31:0] e);
    @(negedge clk);
    evt = e;
    @(negedge clk);
    evt = 32'h0000_0000;
    hs = 2'b00;
    repeat (4) begin
      hs = hs | {halt, irq};
      @(negedge clk);
    end
  endtask
  task automatic preset();
    @(negedge clk);
    prst = 1'b1;
    @(negedge clk);
    prst = 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic test_done();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // Whole run is far below this span
  initial begin
    #300000;
    n_fail++;
    test_done();
  end
  initial begin
    fork
      u_deo_dbg_model.reset_link();
      begin
        repeat (12) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
      end
    join
    repeat (4) @(negedge clk);
    sw(1'b0, SPR_EVSEL, 32'h0);
    chk(q, 32'h0000_0000);
    sw(1'b0, SPR_ACQ, 32'h0);
    chk(q, 32'h0000_0000);
    $display("reset values done");
    for (int i = 0; i < 12; i++) begin
      lf = lfsr(lf);
      v = (i == 0) ? 32'h0000_00ff : (i == 1) ? 32'h8000_0001 : lf & 32'hff00_00ff;
      sw(1'b1, SPR_EVSEL, v);
      chk(32'(pulse), 32'(v[7:0]));
      chk(wp, wpx(v[7:0]));
      chk(32'(tag), 32'(v[31:24]));
      @(negedge clk);
      chk(wp | 32'(pulse), 32'h0000_0000);
      sw(1'b0, SPR_EVSEL, 32'h0);
      chk(q & 32'hff00_0000, v & 32'hff00_0000);
    end
    lf = lfsr(lf);
    sw(1'b1, SPR_ACQ, lf);
    chk(32'(stb), 32'h1);
    chk(adata, lf);
    @(negedge clk);
    chk(32'(stb), 32'h0);
    sw(1'b0, SPR_ACQ, 32'h0);
    chk(q, lf);
    epe = 1'b0;
    repeat (4) @(negedge clk);
    sw(1'b1, SPR_EVSEL, 32'h0000_000f);
    chk(wp, 32'h0000_0000);
    fire(32'h0000_0020);
    chk(32'(hs), 32'h0);
    epe = 1'b1;
    $display("pulse tests done");
    sw(1'b1, SPR_CTL0, 32'h0000_0a5c);
    dbg(1'b1, RA_EMUC, 32'h1);
    wait_h(1'b1);
    dbg(1'b1, RA_XCTL, XM_M);
    sw(1'b0, SPR_CTL0, 32'h0);
    chk(q & 32'h7fff_ffff, 32'h0000_0a5c);
    dbg(1'b1, RA_OWN, 32'h0);
    sw(1'b1, SPR_CTL0, 32'h0000_0003);
    dbg(1'b0, RA_CTL0, 32'h0);
    chk(q & 32'h7fff_ffff, 32'h0000_0a5c);
    sw(1'b1, SPR_ACQ, 32'h1234_5678);
    chk(32'(stb), 32'h0);
    sw(1'b0, SPR_ACQ, 32'h0);
    chk(q, 32'h0);
    lf = lfsr(lf);
    sw(1'b1, SPR_CNT, lf);
    sw(1'b0, SPR_CNT, 32'h0);
    chk(q, lf);
    dbg(1'b1, RA_OWN, 32'h0000_0008);
    sw(1'b1, SPR_ACQ, lf);
    chk(32'(stb), 32'h1);
    dbg(1'b1, RA_EMUC, 32'h0);
    wait_h(1'b0);
    fire(32'h0000_0020);
    chk(32'(hs), 32'h2);
    dbg(1'b0, RA_XSTAT, 32'h0);
    chk(q & 32'h20, 32'h20);
    sw(1'b0, SPR_STAT, 32'h0);
    chk(q & 32'h20, 32'h0);
    dbg(1'b1, RA_EMUC, 32'h1);
    dbg(1'b1, RA_OWN, 32'h8000_0020);
    dbg(1'b1, RA_EMUC, 32'h0);
    wait_h(1'b0);
    fire(32'h0000_0020);
    chk(32'(hs), 32'h1);
    sw(1'b0, SPR_STAT, 32'h0);
    chk(q & 32'h20, 32'h20);
    den_n = 1'b0;
    wait_h(1'b1);
    den_n = 1'b1;
    wait_h(1'b0);
    $display("ownership tests done");
    dbg(1'b1, RA_EMUC, 32'h1);
    dbg(1'b1, RA_OWN, 32'h8000_00f8);
    dbg(1'b1, RA_CTL0, 32'h3000_00ff);
    dbg(1'b1, RA_EVSEL, 32'h5a00_0000);
    preset();
    dbg(1'b0, RA_CTL0, 32'h0);
    chk(q & 32'h7fff_ffff, 32'h0000_0007);
    sw(1'b0, SPR_STAT, 32'h0);
    chk(q & RST_M, 32'h2000_0000);
    chk(32'(tag), 32'h0);
    dbg(1'b1, RA_OWN, 32'h8000_0000);
    dbg(1'b1, RA_ACQ, 32'hc3c3_0f0f);
    dbg(1'b1, RA_EVSEL, 32'h5a00_0000);
    rtype = 2'b01;
    preset();
    chk(32'(tag), 32'h5a);
    sw(1'b0, SPR_STAT, 32'h0);
    chk(q & RST_M, 32'h1000_0000);
    dbg(1'b0, RA_ACQ, 32'h0);
    chk(q, 32'hc3c3_0f0f);
    ce = 1'b0;
    dbg(1'b1, RA_XCTL, 32'h9000_0000);
    dbg(1'b0, RA_XCTL, 32'h0);
    chk(q & XCTL_M, 32'h9000_0000);
    ce = 1'b1;
    dbg(1'b1, RA_XCTL, 32'h0);
    preset();
    chk(32'(tag), 32'h0);
    $display("reset tests done");
    test_done();
  end
endmodule
`default_nettype wire
